// *** sim/buffered_write_through_monitor_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module buffered_write_through_monitor_tb;
    import wtm_pkg::*;
    localparam int DEPTH = 4;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic cpu_wr_valid = 1'b0;
    wr_entry_type cpu_wr = '0;
    snoop_type snoop = '0;
    logic [1:0] flush_mode = 2'h2;
    logic order_matters = 1'b0;
    logic [CNT_W-1:0] early_level = 4'h2;
    logic [3:0] mem_wait = 4'h6;
    logic cpu_stall_r, bus_req_r, bus_grant, bus_preempt_r, mem_wr_valid_r, mem_wr_done;
    logic sys_hold_r, cache_inval_r, q_empty_r, q_full_r;
    wr_entry_type mem_wr_r;
    logic [ADDR_W-1:0] cache_inval_addr_r;
    logic [CNT_W-1:0] q_count_r;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;
    // Rows: processor write in, same word expected at memory
    wr_entry_type rows [5] = '{'{32'h0000_1000, 32'hA5A5_0001}, '{32'h0000_2004, 32'h5A5A_0002},
        '{32'h0000_3008, 32'hFFFF_0003}, '{32'h8000_000C, 32'h0000_0004}, '{32'h0000_4010, 32'h1234_0005}};
    int rem_exp [4] = '{2, 1, 0, 0};

    buffered_write_through_monitor #(.DEPTH(DEPTH)) i_buffered_write_through_monitor (
        .ref_clk(ref_clk), .rst(rst), .cpu_wr_valid(cpu_wr_valid), .cpu_wr(cpu_wr), .cpu_stall_r(cpu_stall_r),
        .bus_req_r(bus_req_r), .bus_grant(bus_grant), .bus_preempt_r(bus_preempt_r),
        .mem_wr_valid_r(mem_wr_valid_r), .mem_wr_r(mem_wr_r), .mem_wr_done(mem_wr_done), .snoop(snoop),
        .sys_hold_r(sys_hold_r), .cache_inval_r(cache_inval_r), .cache_inval_addr_r(cache_inval_addr_r),
        .flush_mode(flush_mode), .order_matters(order_matters), .early_level(early_level),
        .q_empty_r(q_empty_r), .q_full_r(q_full_r), .q_count_r(q_count_r));
    mem_bus_model i_mem_bus_model (.ref_clk(ref_clk), .rst(rst), .bus_req_r(bus_req_r), .bus_grant(bus_grant),
        .mem_wr_valid_r(mem_wr_valid_r), .mem_wr_r(mem_wr_r), .mem_wr_done(mem_wr_done), .wait_cycles(mem_wait));

    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            conclude();
        end
    end

    // ----------------------------------------
    // Bench tasks
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask
    task automatic chk_val(input string name, input logic [ADDR_W-1:0] exp, input logic [ADDR_W-1:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chk_ent(input string name, input wr_entry_type exp, input wr_entry_type got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Leaves the write valid so back-to-back calls never toggle it
    task automatic push(input wr_entry_type e);
        int n = 0;
        cpu_wr_valid = 1'b1;
        cpu_wr = e;
        while (cpu_stall_r !== 1'b0 && n < 200) begin
            tick(1);
            n++;
        end
        chk_val("stall release", 0, cpu_stall_r);
        tick(1);
    endtask
    task automatic snoop_at(input logic wr, input logic [ADDR_W-1:0] a);
        snoop = '{valid: 1'b1, write: wr, addr: a};
        tick(1);
        snoop.valid = 1'b0;
    endtask
    task automatic wait_hold();
        int n = 0;
        while (sys_hold_r !== 1'b0 && n < 400) begin
            tick(1);
            n++;
        end
        chk_val("hold release", 0, sys_hold_r);
    endtask
    task automatic wait_idle();
        int n = 0;
        while (!(q_empty_r === 1'b1 && mem_wr_valid_r === 1'b0) && n < 400) begin
            tick(1);
            n++;
        end
        chk_val("drain idle", 1, q_empty_r && !mem_wr_valid_r);
    endtask
    task automatic conclude();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        tick(8);
        chk_val("empty in reset", 1, q_empty_r);
        rst = 1'b0;
        tick(1);
        chk_val("req after reset", 0, bus_req_r);
        chk_val("count after reset", 0, q_count_r);
        chk_val("default depth", 5, DEPTH_DEFAULT);
        // Slow memory: queue fills, fifth write waits for a drain
        foreach (rows[i]) begin
            push(rows[i]);
            if (i < DEPTH) chk_val("count", i + 1, q_count_r);
            if (i == DEPTH - 1) chk_val("stall", 1, cpu_stall_r);
            if (i == DEPTH - 1) chk_val("full", 1, q_full_r);
            if (i == DEPTH - 1) chk_val("preempt", 1, bus_preempt_r);
        end
        chk_val("refill while draining", DEPTH, q_count_r);
        cpu_wr_valid = 1'b0;
        chk_val("drained before stall end", 1, i_mem_bus_model.log.size() >= 1);
        wait_idle();
        chk_val("memory writes", 5, i_mem_bus_model.log.size());
        foreach (rows[i]) chk_ent("memory order", rows[i], i_mem_bus_model.log[i]);
        // Read hits in every flush mode, duplicate address in slots 1 and 2
        mem_wait = 4'h8;
        for (int m = 0; m < 4; m++) begin
            flush_mode = m[1:0];
            push(rows[0]);
            push(rows[1]);
            push(rows[1]);
            push(rows[2]);
            cpu_wr_valid = 1'b0;
            snoop_at(1'b0, 32'h8000_1000);
            chk_val("miss hold", 0, sys_hold_r);
            tick(1);
            snoop_at(1'b0, rows[1].addr);
            chk_val("read hit hold", 1, sys_hold_r);
            chk_val("read inval", 0, cache_inval_r);
            wait_hold();
            chk_val("left after flush", rem_exp[m], q_count_r);
            wait_idle();
        end
        // Unordered write hit cancels the middle entry
        i_mem_bus_model.log.delete();
        push(rows[0]);
        push(rows[1]);
        push(rows[2]);
        cpu_wr_valid = 1'b0;
        snoop_at(1'b1, rows[1].addr);
        chk_val("inval", 1, cache_inval_r);
        chk_val("inval addr", rows[1].addr, cache_inval_addr_r);
        chk_val("count after cancel", 2, q_count_r);
        wait_idle();
        chk_val("writes after cancel", 2, i_mem_bus_model.log.size());
        chk_ent("kept first", rows[0], i_mem_bus_model.log[0]);
        chk_ent("moved up", rows[2], i_mem_bus_model.log[1]);
        // Ordered write hit drains and holds the system write
        order_matters = 1'b1;
        i_mem_bus_model.log.delete();
        push(rows[3]);
        push(rows[4]);
        cpu_wr_valid = 1'b0;
        snoop_at(1'b1, rows[4].addr);
        chk_val("ordered hold", 1, sys_hold_r);
        chk_val("ordered inval", 1, cache_inval_r);
        wait_hold();
        chk_val("ordered drained", 0, q_count_r);
        chk_ent("newest last", rows[4], i_mem_bus_model.log[1]);
        // Reset in mid-run with entries pending
        push(rows[0]);
        push(rows[1]);
        cpu_wr_valid = 1'b0;
        rst = 1'b1;
        tick(1);
        chk_val("mid reset empty", 1, q_empty_r);
        chk_val("mid reset count", 0, q_count_r);
        chk_val("mid reset req", 0, bus_req_r);
        rst = 1'b0;
        tick(4);
        conclude();
    end
endmodule
`default_nettype wire

// *** sim/bwtm_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module bwtm_asserts
    import wtm_pkg::*;
#(
    parameter int DEPTH = DEPTH_DEFAULT
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Processor side
    input wire logic cpu_wr_valid,
    input wire logic cpu_stall_r,
    // Bus and memory
    input wire logic bus_req_r,
    input wire logic bus_grant,
    input wire logic mem_wr_valid_r,
    input wire wr_entry_type mem_wr_r,
    input wire logic mem_wr_done,
    // Monitor
    input wire snoop_type snoop,
    input wire logic sys_hold_r,
    input wire logic cache_inval_r,
    input wire logic [ADDR_W-1:0] cache_inval_addr_r,
    // Status
    input wire logic q_empty_r,
    input wire logic q_full_r,
    input wire logic [CNT_W-1:0] q_count_r
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_reset_empty: assert property (disable iff (1'b0) rst |=> q_empty_r && !bus_req_r && q_count_r == CNT_ZERO)
        else $error("queue not cleared by reset");
    a_push_count: assert property ((cpu_wr_valid && !cpu_stall_r && !(mem_wr_valid_r && mem_wr_done) && !snoop.valid)
        |=> q_count_r == $past(q_count_r) + CNT_ONE) else $error("accepted write not counted");
    a_full_stall: assert property ((q_count_r == DEPTH) |-> q_full_r && cpu_stall_r)
        else $error("full queue without stall");
    a_grant_write: assert property (bus_req_r && bus_grant && !mem_wr_valid_r |=> mem_wr_valid_r)
        else $error("grant not followed by memory write");
    a_write_req: assert property (mem_wr_valid_r |-> bus_req_r)
        else $error("memory write without bus request");
    a_write_stable: assert property (mem_wr_valid_r && !mem_wr_done |=> mem_wr_valid_r && $stable(mem_wr_r))
        else $error("memory write changed before done");
    a_done_pop: assert property ((mem_wr_valid_r && mem_wr_done && !cpu_wr_valid && !snoop.valid)
        |=> !mem_wr_valid_r && q_count_r == $past(q_count_r) - CNT_ONE) else $error("finished write not removed");
    a_inval_addr: assert property (snoop.valid && snoop.write |=> cache_inval_r && cache_inval_addr_r == $past(snoop.addr))
        else $error("snooped write not invalidated");
    a_read_noinval: assert property (cache_inval_r |-> $past(snoop.valid) && $past(snoop.write))
        else $error("invalidation without snooped write");
    a_empty_flag: assert property (q_empty_r == (q_count_r == CNT_ZERO))
        else $error("empty flag disagrees with count");
    a_hold_ends: assert property ($rose(sys_hold_r) |-> ##[1:200] !sys_hold_r)
        else $error("system hold never released");

    c_read_hold: cover property (sys_hold_r);
    c_inval: cover property (cache_inval_r);
    c_stalled: cover property (cpu_stall_r && cpu_wr_valid);
endmodule

bind buffered_write_through_monitor bwtm_asserts #(.DEPTH(DEPTH)) i_bwtm_asserts (
    .ref_clk(ref_clk), .rst(rst), .cpu_wr_valid(cpu_wr_valid), .cpu_stall_r(cpu_stall_r),
    .bus_req_r(bus_req_r), .bus_grant(bus_grant), .mem_wr_valid_r(mem_wr_valid_r), .mem_wr_r(mem_wr_r),
    .mem_wr_done(mem_wr_done), .snoop(snoop), .sys_hold_r(sys_hold_r), .cache_inval_r(cache_inval_r),
    .cache_inval_addr_r(cache_inval_addr_r), .q_empty_r(q_empty_r), .q_full_r(q_full_r), .q_count_r(q_count_r)
);
`default_nettype wire

// *** sim/mem_bus_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module mem_bus_model
    import wtm_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Arbiter and memory
    input wire logic bus_req_r,
    output logic bus_grant,
    input wire logic mem_wr_valid_r,
    input wire wr_entry_type mem_wr_r,
    output logic mem_wr_done,
    // Extra cycles before grant and before done
    input wire logic [3:0] wait_cycles
);
    logic [3:0] cnt_r;
    wr_entry_type log [$];

    // Grant and done are single pulses, so a slow design cannot see them twice
    always_ff @(posedge ref_clk) begin
        bus_grant <= 1'b0;
        mem_wr_done <= 1'b0;
        if (rst) begin
            cnt_r <= 4'h0;
        end else if (bus_req_r && !mem_wr_valid_r && !bus_grant) begin
            cnt_r <= (cnt_r >= wait_cycles) ? 4'h0 : cnt_r + 4'h1;
            bus_grant <= (cnt_r >= wait_cycles);
        end else if (mem_wr_valid_r && !mem_wr_done) begin
            cnt_r <= (cnt_r >= wait_cycles) ? 4'h0 : cnt_r + 4'h1;
            mem_wr_done <= (cnt_r >= wait_cycles);
            if (cnt_r >= wait_cycles) begin
                log.push_back(mem_wr_r);
            end
        end
    end
endmodule
`default_nettype wire

// *** verilog/buffered_write_through_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module buffered_write_through_monitor
    import wtm_pkg::*;
#(
    // Build-time depth, one to eight entries
    parameter int DEPTH = DEPTH_DEFAULT // RL15
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,

    // Processor write port
    input wire logic cpu_wr_valid,
    input wire wr_entry_type cpu_wr,
    output logic cpu_stall_r,

    // System bus arbitration
    output logic bus_req_r,
    input wire logic bus_grant,
    output logic bus_preempt_r,

    // Main memory write
    output logic mem_wr_valid_r,
    output wr_entry_type mem_wr_r,
    input wire logic mem_wr_done,

    // System bus monitor
    input wire snoop_type snoop,
    output logic sys_hold_r,

    // Local cache invalidation
    output logic cache_inval_r,
    output logic [ADDR_W-1:0] cache_inval_addr_r,

    // Policy
    input wire logic [1:0] flush_mode,
    input wire logic order_matters,
    input wire logic [CNT_W-1:0] early_level,

    // Queue status
    output logic q_empty_r,
    output logic q_full_r,
    output logic [CNT_W-1:0] q_count_r
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    drain_state_type state_r;
    drain_state_type state_nxt;
    flush_mode_type mode;

    logic push;
    logic pop;
    logic [DEPTH-1:0] remove;
    logic [DEPTH-1:0] cancel;
    logic [DEPTH-1:0] hit;
    wr_entry_type head;

    logic rd_hit;
    logic wr_hit;
    logic [CNT_W-1:0] target;
    logic [CNT_W-1:0] flush_left_r;
    logic [CNT_W-1:0] flush_left_nxt;
    logic [CNT_W-1:0] flush_base;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Entries from the head through the oldest or youngest hit
    function automatic logic [CNT_W-1:0] hit_span(
        input logic [DEPTH-1:0] h,
        input logic youngest
    );
        logic [CNT_W-1:0] span;
        logic found;
        span = CNT_ZERO;
        found = 1'b0;
        for (int i = 0; i < DEPTH; i++) begin
            if (h[i] && (youngest || !found)) begin
                span = CNT_W'(i + 1);
                found = 1'b1;
            end
        end
        return span;
    endfunction

    // ------------------------------------------------------------
    // Queue
    // ------------------------------------------------------------
    wb_queue #(
        .DEPTH(DEPTH)
    ) i_wb_queue (
        .ref_clk(ref_clk),
        .rst(rst),
        .push(push),
        .push_entry(cpu_wr),
        .remove(remove),
        .cmp_addr(snoop.addr),
        .hit(hit),
        .head(head),
        .count_r(q_count_r),
        .empty_r(q_empty_r),
        .full_r(q_full_r)
    );

    // Flags are registered, so a write that meets full is never taken
    assign push = cpu_wr_valid && !q_full_r; // RL1 RL5

    // Head pops only once memory has taken it; a cancel before the grant can remove it earlier
    assign pop = (state_r == ST_WRITE) && mem_wr_done; // RL2

    // ------------------------------------------------------------
    // Snoop classification
    // ------------------------------------------------------------
    // Reads consult the queue only; the cache never sees them
    assign rd_hit = snoop.valid && !snoop.write && (|hit); // RL8 RL9
    assign wr_hit = snoop.valid && snoop.write && (|hit);

    // Head in flight or just granted stays: mem_wr_r already carries it
    always_comb begin
        cancel = '0;
        if (wr_hit && !order_matters) begin
            cancel = hit; // RL11
            if (state_r == ST_WRITE || state_nxt == ST_WRITE) begin
                cancel[0] = 1'b0;
            end
        end
    end

    always_comb begin
        remove = cancel; // RL12
        if (pop) begin
            remove[0] = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Flush depth
    // ------------------------------------------------------------
    assign mode = flush_mode_type'(flush_mode);

    always_comb begin
        target = CNT_ZERO;
        if (rd_hit) begin
            unique case (mode)
                FLUSH_WORD: target = hit_span(hit, 1'b0); // RL10
                FLUSH_THROUGH: target = hit_span(hit, 1'b1);
                FLUSH_ALL: target = q_count_r;
                default: target = q_count_r;
            endcase
        end
        // System write waits until every older buffered write is out
        if (wr_hit && order_matters) begin
            target = q_count_r; // RL13
        end
        // Slot 0 leaving at this edge needs no further hold
        if (pop && target != CNT_ZERO) begin
            target = target - CNT_ONE;
        end
    end

    always_comb begin
        flush_base = flush_left_r;
        if (pop && flush_left_r != CNT_ZERO) begin
            flush_base = flush_left_r - CNT_ONE;
        end
        if (q_empty_r) begin
            flush_base = CNT_ZERO;
        end
        flush_left_nxt = (target > flush_base) ? target : flush_base;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            flush_left_r <= CNT_ZERO;
            sys_hold_r <= 1'b0;
        end else begin
            flush_left_r <= flush_left_nxt;
            // Held system cycle retries once the flushed entries are gone
            sys_hold_r <= flush_left_nxt != CNT_ZERO; // RL9 RL13
        end
    end

    // ------------------------------------------------------------
    // Drain sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (!q_empty_r) begin
                    state_nxt = ST_REQ; // RL3
                end
            end
            ST_REQ: begin
                if (q_empty_r) begin
                    state_nxt = ST_IDLE;
                end else if (bus_grant) begin
                    state_nxt = ST_WRITE; // RL3
                end
            end
            ST_WRITE: begin
                if (mem_wr_done) begin
                    state_nxt = (q_count_r > CNT_ONE) ? ST_REQ : ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------
    // Bus request and memory write
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bus_req_r <= 1'b0; // RL19
        end else begin
            // Held through the write, dropped with the last done
            bus_req_r <= state_nxt != ST_IDLE; // RL3
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mem_wr_valid_r <= 1'b0;
            mem_wr_r <= '0;
        end else begin
            mem_wr_valid_r <= state_nxt == ST_WRITE;
            if (state_r == ST_REQ && state_nxt == ST_WRITE) begin
                mem_wr_r <= head; // RL2
            end
        end
    end

    // Asks the arbiter to break a long transfer before the queue fills
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bus_preempt_r <= 1'b0;
        end else begin
            bus_preempt_r <= !q_empty_r && (q_count_r >= early_level) && (state_nxt == ST_REQ); // RL17
        end
    end

    // ------------------------------------------------------------
    // Processor stall
    // ------------------------------------------------------------
    // Released at the same edge where a drain frees a slot
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cpu_stall_r <= 1'b0;
        end else begin
            cpu_stall_r <= (q_count_r == CNT_W'(DEPTH)) && !pop && !(|cancel)
                || (q_count_r == CNT_W'(DEPTH - 1)) && push && !pop && !(|cancel); // RL5
        end
    end

    // ------------------------------------------------------------
    // Cache invalidation
    // ------------------------------------------------------------
    // Any foreign write may hit a cached copy, buffered or not
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cache_inval_r <= 1'b0;
            cache_inval_addr_r <= '0;
        end else begin
            cache_inval_r <= snoop.valid && snoop.write; // RL14 RL11
            if (snoop.valid && snoop.write) begin
                cache_inval_addr_r <= snoop.addr;
            end
        end
    end
endmodule
`default_nettype wire

// *** verilog/wb_queue.sv ***
`timescale 1ns/1ps
`default_nettype none
module wb_queue
    import wtm_pkg::*;
#(
    parameter int DEPTH = DEPTH_DEFAULT
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Fill side
    input wire logic push,
    input wire wr_entry_type push_entry,
    // Removal, any set of slots
    input wire logic [DEPTH-1:0] remove,
    // Parallel compare
    input wire logic [ADDR_W-1:0] cmp_addr,
    output logic [DEPTH-1:0] hit,
    // Head and status
    output wr_entry_type head,
    output logic [CNT_W-1:0] count_r,
    output logic empty_r,
    output logic full_r
);
    // Register array, so every slot can be compared in the same cycle
    wr_entry_type ent_r [DEPTH]; // RL1 RL7
    wr_entry_type ent_nxt [DEPTH];
    logic [DEPTH-1:0] vld_r;
    logic [DEPTH-1:0] vld_nxt;
    logic [CNT_W-1:0] count_nxt;

    // ------------------------------------------------------------
    // Compaction
    // ------------------------------------------------------------
    // Kept slots close up in order; slots ahead of the first gap never move
    always_comb begin
        int k;
        k = 0;
        vld_nxt = '0;
        for (int i = 0; i < DEPTH; i++) begin
            ent_nxt[i] = ent_r[i];
        end
        for (int i = 0; i < DEPTH; i++) begin
            if (vld_r[i] && !remove[i]) begin // RL12
                ent_nxt[k] = ent_r[i];
                vld_nxt[k] = 1'b1;
                k++;
            end
        end
        if (push && k < DEPTH) begin // RL4
            ent_nxt[k] = push_entry;
            vld_nxt[k] = 1'b1;
            k++;
        end
        count_nxt = k[CNT_W-1:0];
    end

    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            hit[i] = vld_r[i] && addr_hit(ent_r[i].addr, cmp_addr); // RL7
        end
    end

    assign head = ent_r[0]; // RL2

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            vld_r <= '0; // RL19
            count_r <= CNT_ZERO;
            empty_r <= 1'b1;
            full_r <= 1'b0;
        end else begin
            vld_r <= vld_nxt;
            count_r <= count_nxt;
            empty_r <= count_nxt == CNT_ZERO; // RL6
            full_r <= count_nxt == CNT_W'(DEPTH);
        end
    end

    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < DEPTH; i++) begin
            ent_r[i] <= ent_nxt[i];
        end
    end
endmodule
`default_nettype wire

// *** verilog/wtm_pkg.sv ***
// Function
// [RL1] Each processor write is held as a data word plus its address side by side.
// [RL2] Queued writes go to memory oldest first, data to its paired address.
// [RL3] A non-empty queue requests the system bus and writes only once granted.
// [RL4] With depth above one, a new write is taken while an old one drains.
// [RL5] A full queue stalls the processor until one word reaches memory.
// [RL6] The queue supports writes and reads and reports empty, full and count.
// [RL7] Every system bus address is compared with all valid entries at once.
// [RL8] System reads are checked against the queue only, never the cache tags.
// [RL9] A system read that hits is held off while buffered data is written first.
// [RL10] Read-hit flush covers the word, entries through it, or the whole queue.
// [RL11] Unordered write hit cancels matching entries and invalidates the cached line.
// [RL12] Cancelling shifts later entries forward one place, earlier ones stay put. The code shifts each kept entry up by the number of removed slots ahead of it.
// [RL13] Ordered write hit drains everything first, so the newest write lands last.
// [RL14] Any system bus write by another agent invalidates the cached line.
// [RL15] Queue depth is a build-time parameter from one to eight entries.
// [RL16] Stored addresses are physical; compare may be limited to real address bits.
// [RL17] Early draining may preempt a long system transfer such as DMA.
// [RL18] Default depth is worst grant wait plus write time over write gap.
// [RL19] Reset empties the queue, reports empty and drops any bus request.
`default_nettype none
package wtm_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int DEPTH_MAX = 8;
    localparam int CNT_W = 4;

    // Sizing figures in ns; default depth follows from them
    localparam int BUS_WAIT_NS = 1000;
    localparam int MEM_WR_NS = 200;
    localparam int CPU_WR_GAP_NS = 250;
    localparam int DEPTH_DEFAULT = (BUS_WAIT_NS + MEM_WR_NS + CPU_WR_GAP_NS - 1) / CPU_WR_GAP_NS; // RL18

    // Bits that take part in the compare; narrow to the real physical address bits
    localparam logic [ADDR_W-1:0] REAL_ADDR_MASK = 32'hFFFF_FFFF; // RL16

    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } wr_entry_type;

    typedef struct packed {
        logic valid;
        logic write;
        logic [ADDR_W-1:0] addr;
    } snoop_type;

    typedef enum logic [1:0] {
        FLUSH_WORD = 2'h0,
        FLUSH_THROUGH = 2'h1,
        FLUSH_ALL = 2'h2
    } flush_mode_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_REQ = 2'h1,
        ST_WRITE = 2'h3
    } drain_state_type;

    function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
        return ((a ^ b) & REAL_ADDR_MASK) == '0;
    endfunction
endpackage
`default_nettype wire
